//--- logic/srbl_params.svh
// srbl_params.svh: offsets, data width and timing counts of the serial RAM loader
// assumes: included by the loader module, by bare name
`ifndef SRBL_PARAMS_SVH
`define SRBL_PARAMS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SRBL_CLK_HZ 40000000
`define SRBL_BAUD 9600
// cycles per bit, rounded to nearest (4166.67 -> 4167)
`define SRBL_BIT_CYC ((`SRBL_CLK_HZ + `SRBL_BAUD / 2) / `SRBL_BAUD)

// ----------------------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------------------
`define SRBL_LEN_ADDR 8'h50
`define SRBL_ENTRY_ADDR 8'h51
`define SRBL_DATA_BITS 4'h8

`endif

//--- logic/srbl_pkg.sv
// srbl_pkg.sv: types of the serial RAM loader
// assumes: srbl_params.svh is on the include path
package srbl_pkg;
	typedef enum logic [1:0] {
		SRBL_IDLE,
		SRBL_START,
		SRBL_DATA,
		SRBL_STOP
	} srbl_rx_state_type;

	typedef enum logic [1:0] {
		SRBL_OFF,
		SRBL_WAIT_LEN,
		SRBL_LOAD,
		SRBL_DONE
	} srbl_load_state_type;

	// one RAM write
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} srbl_ram_wr_type;
endpackage

//--- logic/srbl_loader.sv
// srbl_loader.sv: serial bootstrap loader into on-chip RAM
// assumes: ram write port accepts one write per cycle; boot_sel_i is sampled at reset release;
// the cpu waits for run_o and then starts at run_addr_o
// inputs are taken as synchronous to sys_clk_i, so no synchroniser stands here
`timescale 1ns/1ps
`include "srbl_params.svh"

module srbl_loader #(
	parameter int BIT_CYC = `SRBL_BIT_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// strap and serial line
	input wire logic boot_sel_i,
	input wire logic async_serial_port_rx_i,
	// ram write port
	output srbl_pkg::srbl_ram_wr_type ram_wr_o,
	// handover to cpu
	output logic active_o,
	output logic run_o,
	output logic [7:0] run_addr_o,
	output logic frame_err_o
);
	import srbl_pkg::*;

	// ------------------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------------------
	// the strap is caught on the first clock after reset, never by the reset itself
	// a strap that moves later is ignored until the next reset
	logic strap_taken;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_taken <= 1'b0;
		end else begin
			strap_taken <= 1'b1;
		end
	end
	wire start_boot = !strap_taken && boot_sel_i;

	// ------------------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------------------
	// counters load one less than the wait, since the tick is the zero state
	localparam int CW = $clog2(BIT_CYC + 1);
	localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2 - 1);

	srbl_rx_state_type rx_state, next_rx_state;
	logic [CW-1:0] baud_cnt, next_baud_cnt;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic rx_valid, next_rx_valid;
	logic rx_err, next_rx_err;
	logic rx_en;

	wire tick = baud_cnt == '0;
	always_comb begin
		next_rx_state = rx_state;
		next_baud_cnt = tick ? '0 : baud_cnt - CW'(1);
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_rx_valid = 1'b0;
		next_rx_err = 1'b0;
		unique case (rx_state)
			SRBL_IDLE: begin
				// a start is only looked for while the loader still wants bytes
				if (rx_en && !async_serial_port_rx_i) begin
					next_rx_state = SRBL_START;
					next_baud_cnt = HALF;
				end
			end
			SRBL_START: begin
				if (tick) begin
					// a start bit that is gone at mid-bit was a glitch
					next_rx_state = async_serial_port_rx_i ? SRBL_IDLE : SRBL_DATA;
					next_baud_cnt = FULL;
					next_bit_cnt = '0;
				end
			end
			SRBL_DATA: begin
				if (tick) begin
					// lsb arrives first, so bits enter at the top and shift down
					next_shift = {async_serial_port_rx_i, shift[7:1]};
					next_bit_cnt = bit_cnt + 4'h1;
					next_baud_cnt = FULL;
					if (bit_cnt == `SRBL_DATA_BITS - 4'h1) begin
						next_rx_state = SRBL_STOP;
					end
				end
			end
			SRBL_STOP: begin
				// a low stop bit drops the byte and raises the error pulse
				if (tick) begin
					next_rx_state = SRBL_IDLE;
					next_rx_valid = async_serial_port_rx_i;
					next_rx_err = !async_serial_port_rx_i;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_state <= SRBL_IDLE;
			baud_cnt <= '0;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			rx_valid <= 1'b0;
			rx_err <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			baud_cnt <= next_baud_cnt;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			rx_valid <= next_rx_valid;
			rx_err <= next_rx_err;
		end
	end

	// ------------------------------------------------------------------------
	// load sequencer
	// ------------------------------------------------------------------------
	srbl_load_state_type ld_state, next_ld_state;
	logic [7:0] wr_addr, next_wr_addr;
	logic [7:0] count, next_count;
	srbl_ram_wr_type next_wr;

	assign rx_en = (ld_state == SRBL_WAIT_LEN) || (ld_state == SRBL_LOAD);

	// the stored length is rewritten after every data byte, so ram at 50h
	// always holds the live count just as the software loader would leave it
	wire [7:0] count_dec = count - 8'h01;
	// a data byte went out last cycle; the length write itself does not count
	wire data_wr_seen = ram_wr_o.we && (ram_wr_o.addr != `SRBL_LEN_ADDR);

	always_comb begin
		next_ld_state = ld_state;
		next_wr_addr = wr_addr;
		next_count = count;
		next_wr = '0;
		unique case (ld_state)
			SRBL_OFF: begin
				if (start_boot) begin
					next_ld_state = SRBL_WAIT_LEN;
				end
			end
			SRBL_WAIT_LEN: begin
				if (rx_valid) begin
					next_wr = '{we: 1'b1, addr: `SRBL_LEN_ADDR, data: shift};
					next_count = shift;
					next_wr_addr = `SRBL_LEN_ADDR + 8'h01;
					// a length of one means no program bytes: jump at once
					next_ld_state = (shift == 8'h01) ? SRBL_DONE : SRBL_LOAD;
				end
			end
			SRBL_LOAD: begin
				if (rx_valid) begin
					next_wr = '{we: 1'b1, addr: wr_addr, data: shift};
					next_wr_addr = wr_addr + 8'h01;
					next_count = count_dec;
				end else begin
					if (data_wr_seen) begin
						// the count follows one cycle behind its data byte, the last one included
						next_wr = '{we: 1'b1, addr: `SRBL_LEN_ADDR, data: count};
					end
					// the length counts itself, so one left means the image is complete;
					// a length of zero carries no image and jumps at once
					if (count_dec == 8'h00 || count == 8'h00) begin
						next_ld_state = SRBL_DONE;
					end
				end
			end
			SRBL_DONE: begin
				// reception stays shut until the next reset
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ld_state <= SRBL_OFF;
			wr_addr <= `SRBL_LEN_ADDR;
			count <= 8'h00;
			ram_wr_o <= '0;
		end else begin
			ld_state <= next_ld_state;
			wr_addr <= next_wr_addr;
			count <= next_count;
			ram_wr_o <= next_wr;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			active_o <= 1'b0;
			run_o <= 1'b0;
			run_addr_o <= 8'h00;
			frame_err_o <= 1'b0;
		end else begin
			active_o <= rx_en;
			run_o <= ld_state == SRBL_DONE;
			// constant, but registered so that every port leaves a flip-flop
			run_addr_o <= `SRBL_ENTRY_ADDR;
			// one pulse for each byte dropped on a low stop bit
			frame_err_o <= rx_err;
		end
	end
endmodule

//--- dv/srbl_chk.sv
// srbl_chk.sv: port checks of the serial RAM loader
// assumes: bound to srbl_loader, one clock domain
`timescale 1ns/1ps
module srbl_chk (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// watched outputs
	input wire srbl_pkg::srbl_ram_wr_type ram_wr_o,
	input wire logic active_o,
	input wire logic run_o,
	input wire logic [7:0] run_addr_o,
	input wire logic frame_err_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	entry_addr_a: assert property (run_o |-> run_addr_o == 8'h51) else $error("entry address wrong");
	run_hold_a: assert property (run_o |=> run_o) else $error("run dropped");
	rx_stop_a: assert property (run_o |=> !active_o) else $error("still receiving after run");
	wr_base_a: assert property (ram_wr_o.we |-> ram_wr_o.addr >= 8'h50) else $error("write below base");
	idle_quiet_a: assert property (!active_o [*5] |-> !ram_wr_o.we) else $error("write while idle");
	count_wr_a: assert property (ram_wr_o.we && ram_wr_o.addr != 8'h50 |=> ram_wr_o.we && ram_wr_o.addr == 8'h50)
		else $error("count not rewritten after data byte");
	run_no_wr_a: assert property (run_o |-> !ram_wr_o.we) else $error("write after run");
	ferr_drop_a: assert property (frame_err_o |-> !ram_wr_o.we) else $error("write of a broken frame");
endmodule
bind srbl_loader srbl_chk chk_u (.sys_clk_i, .arst_n_i, .ram_wr_o, .active_o, .run_o, .run_addr_o, .frame_err_o);

//--- dv/srbl_host.sv
// srbl_host.sv: host serial sender, raw binary characters
// assumes: bit time counted in clocks of the loader
`timescale 1ns/1ps
module srbl_host #(
	parameter int BIT_CYC = 16
) (
	input wire logic sys_clk_i,
	output logic tx_o
);
	// line idles high between characters
	initial tx_o = 1'b1;
	task automatic send_frame(input logic [7:0] b, input logic stop_bit);
		for (int i = 0; i < 10; i++) begin
			tx_o = (i == 0) ? 1'b0 : (i == 9) ? stop_bit : b[i-1];
			repeat (BIT_CYC) @(negedge sys_clk_i);
		end
		// a broken frame is followed by idle line so the receiver finds the next start
		if (!stop_bit) begin
			tx_o = 1'b1;
			repeat (2 * BIT_CYC) @(negedge sys_clk_i);
		end
	endtask
	task automatic send(input logic [7:0] b);
		send_frame(b, 1'b1);
	endtask
endmodule

//--- dv/testbench.sv
// testbench.sv: loads a random image, then tries the strap off and an empty image
// assumes: srbl_pkg and srbl_host compiled first
`timescale 1ns/1ps
module testbench;
	import srbl_pkg::*;
	localparam int BC = 16;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic boot_sel_i = 1'b1;
	logic rx, active, run, ferr;
	logic [7:0] run_addr;
	srbl_ram_wr_type ram_wr;
	logic [15:0] exp_q[$];
	logic [15:0] ferr_q[$];
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int seed = 75;
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	srbl_host #(.BIT_CYC(BC)) host_u (.sys_clk_i(sys_clk_i), .tx_o(rx));
	srbl_loader #(.BIT_CYC(BC)) dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .boot_sel_i(boot_sel_i),
		.async_serial_port_rx_i(rx), .ram_wr_o(ram_wr), .active_o(active), .run_o(run),
		.run_addr_o(run_addr), .frame_err_o(ferr));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// monitor: sampled at the falling edge, clear of the write edge
	// ------------------------------------------------------------------
	always @(negedge sys_clk_i) if (ram_wr.we === 1'b1) begin
		if (exp_q.size() == 0) chk("spurious write", 16'h0, 16'h1);
		else chk("ram write", exp_q.pop_front(), {ram_wr.addr, ram_wr.data});
	end
	always @(negedge sys_clk_i) if (ferr === 1'b1) begin
		if (ferr_q.size() == 0) chk("spurious frame error", 16'h0, 16'h1);
		else chk("frame error", ferr_q.pop_front(), {15'h0, ferr});
	end
	always @(posedge sys_clk_i) if (++cyc == 20000) begin
		n_errors++;
		final_report();
	end
	initial begin
		logic [7:0] len, d;
		repeat (5) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk("active", 16'h1, {15'h0, active});
		len = 8'h02 + {6'h0, 2'($random(seed))};
		exp_q.push_back({8'h50, len});
		host_u.send(len);
		// a broken frame inside the image is dropped: no write, no count step
		ferr_q.push_back(16'h1);
		host_u.send_frame(8'($random(seed)), 1'b0);
		for (int k = 1; k < len; k++) begin
			d = 8'($random(seed));
			exp_q.push_back({8'h50 + 8'(k), d});
			// the count rewrite follows every data write, the last one too
			exp_q.push_back({8'h50, len - 8'(k)});
			host_u.send(d);
		end
		for (int i = 0; i < 40 && run !== 1'b1; i++) @(negedge sys_clk_i);
		chk("run", 16'h1, {15'h0, run});
		chk("entry", 16'h0051, {8'h0, run_addr});
		chk("pending writes", 16'h0, 16'(exp_q.size()));
		chk("pending frame errors", 16'h0, 16'(ferr_q.size()));
		$display("test load done");
		host_u.send(8'ha5);
		repeat (4) @(negedge sys_clk_i);
		chk("active after run", 16'h0, {15'h0, active});
		$display("test after done");
		// second reset with the strap off: the loader must stay silent
		arst_n_i = 1'b0;
		boot_sel_i = 1'b0;
		repeat (5) @(negedge sys_clk_i);
		chk("run in reset", 16'h0, {15'h0, run});
		arst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk("active strap off", 16'h0, {15'h0, active});
		host_u.send(8'h01);
		chk("run strap off", 16'h0, {15'h0, run});
		$display("test strap off done");
		// third reset with the strap on and a length of one: nothing to load, jump at once
		arst_n_i = 1'b0;
		boot_sel_i = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		exp_q.push_back(16'h5001);
		host_u.send(8'h01);
		chk("run empty image", 16'h1, {15'h0, run});
		chk("pending empty image", 16'h0, 16'(exp_q.size()));
		$display("test empty image done");
		final_report();
	end
endmodule
